// file: acsc_ctrl.sv
// serial control and conversion sequencing of a four-channel converter
`timescale 1ns/1ns
// Function
// - sample input bit each rising clock
// - skip leading zeros, first one starts
// - single-ended channel decode against common
// - differential pair decode
// - external result framed one zero, three zeros; internal result twelve bits, four zeros
// - unipolar binary, bipolar two's complement
// - output changes on falling edge, MSB first
// - power bits select clock mode
// - strobe one period, then 12 bits
// - external mode tri-states on chip select
// - internal strobe low during conversion
// - internal result MSB after strobe rises
// - internal mode keeps strobe, conversion survives
// - conversion starts falling edge after bit eight
// - start accepted idle or after bit 6
// - chip select toggle aborts external conversion
// - back-to-back conversions every 15 clocks
// - bit3 unipolar, bit2 single-ended
// - track after bit five, hold after eight
// - power bits zero power down at external start, after internal conversion
// - zeros out before first conversion
module acsc_ctrl
   import acsc_pkg::*;
#(
   parameter int CONV_CNT = CONV_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic                serial_clk,
   input  wire logic                chip_select_n,
   input  wire logic                data_in,
   output logic                     data_out,
   output logic                     data_out_oe,
   output logic                     conversion_strobe_out,
   output logic                     conversion_strobe_oe,
   input  wire logic [RES_BITS-1:0] sample_value,
   output logic                     track_active,
   output logic [1:0]               pos_input_sel,
   output logic [1:0]               neg_input_sel,
   output logic                     neg_is_common,
   output logic                     unipolar_mode,
   output logic                     powered_up
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // positive input, single-ended and differential
   function automatic logic [1:0] pos_of(input logic [2:0] sel);
      case (sel)
         SEL_A:   pos_of = IN_0;
         SEL_B:   pos_of = IN_1;
         SEL_C:   pos_of = IN_2;
         SEL_D:   pos_of = IN_3;
         default: pos_of = IN_0;
      endcase
   endfunction

   function automatic logic [1:0] neg_of(input logic [2:0] sel);
      case (sel)
         SEL_A:   neg_of = IN_1;
         SEL_B:   neg_of = IN_0;
         SEL_C:   neg_of = IN_3;
         SEL_D:   neg_of = IN_2;
         default: neg_of = IN_1;
      endcase
   endfunction

   function automatic logic [RES_BITS-1:0] code_of(input logic [RES_BITS-1:0] s,
                                                  input logic uni);
      code_of = uni ? s : {~s[RES_BITS-1], s[RES_BITS-2:0]};
   endfunction

   // ----------------------------------------------------------------
   // link-side state (serial_clk rising edge)
   // ----------------------------------------------------------------
   acsc_state_t         st_reg,    st_next;
   logic [4:0]          bit_reg,   bit_next;
   logic [CB_BITS-1:0]  cb_reg,    cb_next;
   logic [CB_BITS-1:0]  cfg_reg,   cfg_next;
   logic                any_reg,   any_next;
   logic                go_tgl_reg, go_tgl_next;
   logic [RES_BITS-1:0] ext_res_reg, ext_res_next;
   logic                int_go_reg, int_go_next;
   logic [2:0]          dsync_reg;
   logic [RES_BITS-1:0] int_res;
   logic                int_busy, int_done_tgl;
   logic                ctrl_done;

   // a last control bit completes when seven bits are held plus this one
   assign ctrl_done = (st_reg == ACSC_CTRL) && (bit_reg == CNT_HOLD - 5'h01);

   always_comb begin
      st_next      = st_reg;
      bit_next     = bit_reg;
      cb_next      = cb_reg;
      cfg_next     = cfg_reg;
      any_next     = any_reg;
      go_tgl_next  = go_tgl_reg;
      ext_res_next = ext_res_reg;
      int_go_next  = 1'b0;
      case (st_reg)
         ACSC_IDLE, ACSC_INT: begin
            if (data_in) begin
               st_next  = ACSC_CTRL;
               cb_next  = {{(CB_BITS-1){1'b0}}, 1'b1};
               bit_next = 5'h01;
            end
         end
         ACSC_CTRL: begin
            cb_next  = {cb_reg[CB_BITS-2:0], data_in};
            bit_next = bit_reg + 5'h01;
            if (ctrl_done) begin
               cfg_next = {cb_reg[CB_BITS-2:0], data_in};
               any_next = 1'b1;
               bit_next = 5'h00;
               // power bits select mode
               // power-down codes keep the clock mode of a directly preceding 10 or 11 code, external otherwise and after reset
               if (cfg_next[CB_PD1] ? cfg_next[CB_PD0]
                                    : (cfg_reg[CB_PD0] || !cfg_reg[CB_PD1])) begin
                  st_next      = ACSC_EXT;
                  ext_res_next = code_of(sample_value, cfg_next[CB_UNI]);
               end else begin
                  st_next     = ACSC_INT;
                  go_tgl_next = ~go_tgl_reg;
                  int_go_next = 1'b1;
               end
            end
         end
         ACSC_EXT: begin
            bit_next = bit_reg + 5'h01;
            if (data_in && bit_reg >= CNT_RESTART + 5'h01) begin
               st_next  = ACSC_CTRL;
               cb_next  = {{(CB_BITS-1){1'b0}}, 1'b1};
               bit_next = 5'h01;
            end else if (bit_reg == CNT_EXT_END) begin
               st_next = ACSC_IDLE;
            end
         end
         default: st_next = ACSC_IDLE;
      endcase
   end

   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         st_reg  <= ACSC_IDLE;
         bit_reg <= 5'h00;
         cb_reg  <= '0;
      end else begin
         st_reg  <= st_next;
         bit_reg <= bit_next;
         cb_reg  <= cb_next;
      end
   end

   always_ff @(posedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg     <= '0;
         any_reg     <= 1'b0;
         go_tgl_reg  <= 1'b0;
         ext_res_reg <= '0;
         int_go_reg  <= 1'b0;
      end else begin
         cfg_reg     <= chip_select_n ? cfg_reg : cfg_next;
         any_reg     <= chip_select_n ? any_reg : any_next;
         go_tgl_reg  <= chip_select_n ? go_tgl_reg : go_tgl_next;
         ext_res_reg <= chip_select_n ? ext_res_reg : ext_res_next;
         int_go_reg  <= chip_select_n ? 1'b0 : int_go_next;
      end
   end

   // ----------------------------------------------------------------
   // internal conversion on sys_clk and crossings back
   // ----------------------------------------------------------------
   acsc_int_conv #(
      .CYCLES (CONV_CNT)
   ) u_conv (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .start_tgl (go_tgl_reg),
      .sample_in (code_of(sample_value, cfg_reg[CB_UNI])),
      .busy      (int_busy),
      .result    (int_res),
      .done_tgl  (int_done_tgl)
   );

   // done toggle crosses to the link side; the strobe itself stays on sys_clk
   // so that it moves while the host holds the serial clock still
   always_ff @(posedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         dsync_reg   <= 3'h0;
      end else begin
         dsync_reg   <= {dsync_reg[1:0], int_done_tgl};
      end
   end

   // ----------------------------------------------------------------
   // output side (serial_clk falling edge)
   // ----------------------------------------------------------------
   logic [RES_BITS+3:0] osh_reg, osh_next;
   logic                strb_reg, strb_next;
   logic                ext_mode_reg, ext_mode_next;
   logic                trk_reg, trk_next;
   logic                int_ready_reg, int_ready_next;
   logic                dsync_seen_reg, dsync_seen_next;
   logic                pwr_reg, pwr_next;

   always_comb begin
      osh_next        = {osh_reg[RES_BITS+2:0], 1'b0};
      strb_next       = 1'b0;
      ext_mode_next   = ext_mode_reg;
      trk_next        = trk_reg;
      int_ready_next  = 1'b0;
      dsync_seen_next = dsync_seen_reg;
      pwr_next        = pwr_reg;
      if (st_reg == ACSC_CTRL && bit_reg == CNT_TRACK) begin
         trk_next = 1'b1;
         pwr_next = 1'b1;
      end
      // conversion on falling edge after bit eight
      if (st_reg == ACSC_EXT && bit_reg == 5'h00) begin
         trk_next      = 1'b0;
         ext_mode_next = 1'b1;
         strb_next     = 1'b1;
         osh_next      = {1'b0, ext_res_reg, 3'h0};
         pwr_next      = cfg_reg[CB_PD1];
      end else if (int_go_reg) begin
         trk_next      = 1'b0;
         ext_mode_next = 1'b0;
         pwr_next      = cfg_reg[CB_PD1];
      end
      if (dsync_reg[2] != dsync_seen_reg) begin
         dsync_seen_next = dsync_reg[2];
         osh_next        = {int_res, 4'h0};
         int_ready_next  = 1'b1;
      end
   end

   always_ff @(negedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         osh_reg        <= '0;
         strb_reg       <= 1'b0;
         ext_mode_reg   <= 1'b0;
         trk_reg        <= 1'b0;
         int_ready_reg  <= 1'b0;
         dsync_seen_reg <= 1'b0;
         pwr_reg        <= 1'b0;
      end else begin
         osh_reg        <= osh_next;
         strb_reg       <= strb_next;
         ext_mode_reg   <= ext_mode_next;
         trk_reg        <= trk_next;
         int_ready_reg  <= int_ready_next;
         dsync_seen_reg <= dsync_seen_next;
         pwr_reg        <= pwr_next;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   assign data_out    = osh_reg[RES_BITS+3];
   assign data_out_oe = ~chip_select_n;
   assign conversion_strobe_out = ext_mode_reg ? strb_reg : ~int_busy;
   assign conversion_strobe_oe  = ext_mode_reg ? ~chip_select_n : 1'b1;
   assign track_active  = trk_reg;
   assign pos_input_sel = pos_of(cfg_reg[CB_SEL_HI:CB_SEL_LO]);
   assign neg_input_sel = neg_of(cfg_reg[CB_SEL_HI:CB_SEL_LO]);
   assign neg_is_common = cfg_reg[CB_SGL];
   assign unipolar_mode = cfg_reg[CB_UNI];
   assign powered_up    = pwr_reg | int_busy;
endmodule

// file: acsc_ctrl_bench.sv
// self-checking bench for the serial conversion controller
`timescale 1ns/1ns
module acsc_ctrl_bench;
   import acsc_pkg::*;
   localparam int CONV = 20;
   logic                sys_clk, resetn, serial_clk, chip_select_n, data_in;
   logic                data_out, data_out_oe, conversion_strobe_out, conversion_strobe_oe;
   logic                track_active, neg_is_common, unipolar_mode, powered_up, uni, sgl;
   logic [1:0]          pos_input_sel, neg_input_sel;
   logic [RES_BITS-1:0] sample_value;
   logic [15:0]         rx, rx2;
   logic [7:0]          ctrl;
   int                  errors, tests_run, n;
   logic [2:0]          sel_tab [4] = '{SEL_A, SEL_B, SEL_C, SEL_D};
   logic [1:0]          pos_tab [4] = '{IN_0, IN_1, IN_2, IN_3};
   acsc_ctrl #(.CONV_CNT(CONV)) u_acsc_ctrl (
      .sys_clk(sys_clk), .resetn(resetn), .serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .data_in(data_in), .data_out(data_out),
      .data_out_oe(data_out_oe), .conversion_strobe_out(conversion_strobe_out),
      .conversion_strobe_oe(conversion_strobe_oe), .sample_value(sample_value),
      .track_active(track_active), .pos_input_sel(pos_input_sel),
      .neg_input_sel(neg_input_sel), .neg_is_common(neg_is_common),
      .unipolar_mode(unipolar_mode), .powered_up(powered_up));
   acsc_host_model u_acsc_host_model (
      .serial_clk(serial_clk), .chip_select_n(chip_select_n), .data_in(data_in),
      .data_out(data_out), .data_out_oe(data_out_oe));
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic frame_start();
      @(posedge sys_clk);
      #1 u_acsc_host_model.frame_begin();
   endtask
   task automatic sh(input int k, input logic [15:0] tx);
      u_acsc_host_model.shift(k, tx, rx);
   endtask
   task automatic wait_strobe();
      n = 0;
      while (conversion_strobe_out !== 1'b1 && n < CONV + 16) begin
         @(posedge sys_clk);
         n++;
      end
      #1;
   endtask
   // result frame: one leading zero, twelve bits, three trailing zeros
   function automatic logic [15:0] exp16(input logic u);
      return {1'b0, (u ? sample_value : sample_value ^ 12'h800), 3'h0};
   endfunction
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      sample_value = 12'h000;
      errors = 0;
      tests_run = 0;
      repeat (4) @(posedge sys_clk);
      #1 resetn = 1'b1;
      check({conversion_strobe_out, data_out_oe}, 16'h2);
      frame_start();
      sh(16, 16'h0000);
      check(rx, 16'h0000);
      u_acsc_host_model.frame_end();
      // every channel code, both configurations, both polarities
      for (int i = 0; i < 8; i++) begin
         sgl = (i < 4);
         uni = i[0];
         sample_value = 12'h3c5 + 12'(i * 273);
         ctrl = {1'b1, sel_tab[i % 4], uni, sgl, PD_EXT_CLK};
         frame_start();
         if (i > 0) check({conversion_strobe_oe, conversion_strobe_out}, 16'h2);
         sh(i, 16'h0000);
         sh(8, {8'h00, ctrl});
         sh(16, 16'h0000);
         check(rx, exp16(uni));
         check({unipolar_mode, neg_is_common, pos_input_sel}, {12'h0, uni, sgl, pos_tab[i % 4]});
         if (!sgl) check(neg_input_sel, pos_tab[i % 4] ^ 2'h1);
         check(powered_up, 16'h1);
         u_acsc_host_model.frame_end();
         check({conversion_strobe_oe, data_out_oe}, 16'h0);
      end
      // internal clock, select raised during conversion, late readout
      sample_value = 12'h9e1;
      frame_start();
      sh(8, {8'h00, 1'b1, SEL_D, 1'b0, 1'b0, PD_INT_CLK});
      #50 check(conversion_strobe_out, 16'h0);
      u_acsc_host_model.frame_end();
      check({conversion_strobe_oe, data_out_oe}, 16'h2);
      wait_strobe();
      check(conversion_strobe_out, 16'h1);
      repeat (60) @(posedge sys_clk);
      frame_start();
      sh(16, 16'h0000);
      // held result loads after three link edges carry the done toggle over
      check(rx, exp16(1'b0) >> 2);
      check({neg_is_common, neg_input_sel}, {13'h0, 1'b0, IN_2});
      // power bits zero keep the last clock mode, then power down
      sh(8, {8'h00, 1'b1, SEL_A, 1'b1, 1'b1, 2'h0});
      #50 wait_strobe();
      repeat (4) @(posedge sys_clk);
      #1 check(powered_up, 16'h0);
      sh(16, 16'h0000);
      check(rx, exp16(1'b1) >> 2);
      u_acsc_host_model.frame_end();
      // back-to-back external conversions fifteen clocks apart
      frame_start();
      sh(8, {8'h00, 1'b1, SEL_A, 1'b1, 1'b1, PD_EXT_CLK});
      sh(7, 16'h0008);
      rx2 = rx;
      sh(8, {8'h00, 1'b1, SEL_B, 1'b0, 1'b1, PD_EXT_CLK});
      check({3'h0, rx2[6:0], rx[7:2]}, {4'h0, sample_value});
      sh(16, 16'h0000);
      check(rx, exp16(1'b0));
      u_acsc_host_model.frame_end();
      // select toggled mid-conversion aborts, next start bit obeyed
      frame_start();
      sh(8, {8'h00, 1'b1, SEL_C, 1'b1, 1'b1, PD_EXT_CLK});
      sh(5, 16'h0000);
      u_acsc_host_model.frame_end();
      sample_value = 12'h17b;
      frame_start();
      sh(8, {8'h00, 1'b1, SEL_C, 1'b0, 1'b1, PD_EXT_CLK});
      sh(16, 16'h0000);
      check(rx, exp16(1'b0));
      u_acsc_host_model.frame_end();
      print_verdict();
   end
   // watchdog against a hung handshake
   initial begin
      #300000;
      errors++;
      print_verdict();
   end
endmodule

// file: acsc_ctrl_monitor.sv
// port timing checker for the serial conversion controller
`timescale 1ns/1ns
module acsc_ctrl_monitor
   import acsc_pkg::*;
#(
   parameter int CONV_CNT = CONV_CYCLES
) (
   input wire logic                sys_clk,
   input wire logic                resetn,
   input wire logic                serial_clk,
   input wire logic                chip_select_n,
   input wire logic                data_in,
   input wire logic                data_out,
   input wire logic                data_out_oe,
   input wire logic                conversion_strobe_out,
   input wire logic                conversion_strobe_oe,
   input wire logic [RES_BITS-1:0] sample_value,
   input wire logic                track_active,
   input wire logic [1:0]          pos_input_sel,
   input wire logic [1:0]          neg_input_sel,
   input wire logic                neg_is_common,
   input wire logic                unipolar_mode,
   input wire logic                powered_up
);
   logic track_reg;
   logic seen_reg;
   int   low_cnt;
   logic fresh_reg;
   // marks the first falling edge of a new frame, where history is stale
   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) fresh_reg <= 1'b1;
      else fresh_reg <= 1'b0;
   end
   // remember whether any conversion has reached hold
   always_ff @(negedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         track_reg <= 1'b0;
         seen_reg  <= 1'b0;
      end else begin
         track_reg <= track_active;
         seen_reg  <= seen_reg | (track_reg & ~track_active);
      end
   end
   // strobe held low with select high can only be an internal conversion
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) low_cnt <= 0;
      else if (chip_select_n && conversion_strobe_oe && !conversion_strobe_out) low_cnt <= low_cnt + 1;
      else low_cnt <= 0;
   end
   oe_follow_a : assert property (@(posedge sys_clk) disable iff (!resetn)
      data_out_oe == !chip_select_n) else $error("data output enable differs from select");
   strobe_drive_a : assert property (@(posedge sys_clk) disable iff (!resetn)
      !chip_select_n |-> conversion_strobe_oe) else $error("strobe released while selected");
   out_edge_a : assert property (@(posedge sys_clk) disable iff (!resetn)
      $changed(data_out) |-> !serial_clk) else $error("data output moved with clock high");
   track_window_a : assert property (@(negedge serial_clk)
      disable iff (!resetn || chip_select_n)
      $rose(track_active) |-> ##2 track_active ##1 !track_active) else $error("track span wrong");
   ext_pulse_a : assert property (@(negedge serial_clk)
      disable iff (!resetn || chip_select_n)
      !fresh_reg && $fell(track_active) && $rose(conversion_strobe_out)
      |=> !conversion_strobe_out [*8])
      else $error("external strobe pulse not one period");
   zeros_first_a : assert property (@(negedge serial_clk)
      disable iff (!resetn || chip_select_n)
      !seen_reg |-> !data_out) else $error("nonzero output before first conversion");
   diff_pair_a : assert property (@(negedge serial_clk)
      disable iff (!resetn || chip_select_n)
      seen_reg && !neg_is_common |-> neg_input_sel == (pos_input_sel ^ 2'h1))
      else $error("differential pair decode wrong");
   int_conv_time_a : assert property (@(posedge sys_clk) disable iff (!resetn)
      low_cnt <= CONV_CNT + 16) else $error("internal conversion too long");
endmodule
bind acsc_ctrl acsc_ctrl_monitor #(.CONV_CNT(CONV_CNT)) u_acsc_ctrl_monitor (
   .sys_clk(sys_clk), .resetn(resetn), .serial_clk(serial_clk),
   .chip_select_n(chip_select_n), .data_in(data_in), .data_out(data_out),
   .data_out_oe(data_out_oe), .conversion_strobe_out(conversion_strobe_out),
   .conversion_strobe_oe(conversion_strobe_oe), .sample_value(sample_value),
   .track_active(track_active), .pos_input_sel(pos_input_sel),
   .neg_input_sel(neg_input_sel), .neg_is_common(neg_is_common),
   .unipolar_mode(unipolar_mode), .powered_up(powered_up));

// file: acsc_host_model.sv
// host serial master model driving the converter's serial pins
`timescale 1ns/1ns
module acsc_host_model (
   output logic      serial_clk,
   output logic      chip_select_n,
   output logic      data_in,
   input  wire logic data_out,
   input  wire logic data_out_oe
);
   logic dout_last;
   logic dout_pin;
   // released output line shows the inverse of its last driven value
   always @(data_out or data_out_oe) if (data_out_oe) dout_last = data_out;
   assign dout_pin = data_out_oe ? data_out : ~dout_last;
   initial begin
      serial_clk    = 1'b0;
      chip_select_n = 1'b1;
      data_in       = 1'b0;
   end
   task automatic frame_begin();
      #7 chip_select_n = 1'b0;
      #20;
   endtask
   task automatic frame_end();
      #20 chip_select_n = 1'b1;
      data_in = ~data_in;
      #20;
   endtask
   task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         data_in = tx[i];
         #15 serial_clk = 1'b1;
         rx = {rx[14:0], dout_pin};
         #15 serial_clk = 1'b0;
      end
   endtask
endmodule

// file: acsc_int_conv.sv
// internal-clock conversion timer and result holder on sys_clk
`timescale 1ns/1ns
module acsc_int_conv
   import acsc_pkg::*;
#(
   parameter int CYCLES = CONV_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic                start_tgl,
   input  wire logic [RES_BITS-1:0] sample_in,
   output logic                     busy,
   output logic [RES_BITS-1:0]      result,
   output logic                     done_tgl
);
   initial begin
      if (CYCLES < 1 || CYCLES > 65535) $error("CYCLES out of range");
   end

   logic [2:0]          sync_reg,   sync_next;
   logic [15:0]         cnt_reg,    cnt_next;
   logic                busy_reg,   busy_next;
   logic                done_reg,   done_next;
   logic [RES_BITS-1:0] res_reg,    res_next;
   logic                start_evt;

   // ----------------------------------------------------------------
   // start toggle crossing and conversion timer
   // ----------------------------------------------------------------
   always_comb begin
      sync_next = {sync_reg[1:0], start_tgl};
      start_evt = sync_reg[2] ^ sync_reg[1];
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      done_next = done_reg;
      res_next  = res_reg;
      if (start_evt) begin
         busy_next = 1'b1;
         cnt_next  = 16'(CYCLES - 1);
      end else if (busy_reg) begin
         if (cnt_reg == 16'h0000) begin
            busy_next = 1'b0;
            res_next  = sample_in;
            done_next = ~done_reg;
         end else begin
            cnt_next = cnt_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_reg <= 3'h0;
         cnt_reg  <= 16'h0000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         res_reg  <= '0;
      end else begin
         sync_reg <= sync_next;
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         res_reg  <= res_next;
      end
   end

   assign busy     = busy_reg;
   assign result   = res_reg;
   assign done_tgl = done_reg;
endmodule

// file: acsc_pkg.sv
// package of constants and types for the serial conversion controller
package acsc_pkg;
   // ----------------------------------------------------------------
   // control byte field positions
   // ----------------------------------------------------------------
   localparam int CB_START  = 7;
   localparam int CB_SEL_HI = 6;
   localparam int CB_SEL_LO = 4;
   localparam int CB_UNI    = 3;
   localparam int CB_SGL    = 2;
   localparam int CB_PD1    = 1;
   localparam int CB_PD0    = 0;
   localparam int CB_BITS   = 8;
   localparam int RES_BITS  = 12;
   // ----------------------------------------------------------------
   // channel select codes and mux encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_A = 3'h1;
   localparam logic [2:0] SEL_B = 3'h5;
   localparam logic [2:0] SEL_C = 3'h2;
   localparam logic [2:0] SEL_D = 3'h6;
   localparam logic [1:0] IN_0  = 2'h0;
   localparam logic [1:0] IN_1  = 2'h1;
   localparam logic [1:0] IN_2  = 2'h2;
   localparam logic [1:0] IN_3  = 2'h3;
   localparam logic [1:0] PD_INT_CLK = 2'h2; // 10 selects internal clock
   localparam logic [1:0] PD_EXT_CLK = 2'h3;
   // ----------------------------------------------------------------
   // link-side counts (serial clock periods)
   // ----------------------------------------------------------------
   localparam logic [4:0] CNT_TRACK   = 5'h05; // tracking after fifth bit
   localparam logic [4:0] CNT_HOLD    = 5'h08; // hold after eighth bit
   localparam logic [4:0] CNT_RESTART = 5'h06; // start allowed after result bit 6
   localparam logic [4:0] CNT_EXT_END = 5'h0f; // strobe + 12 bits + 3 zeros
   // ----------------------------------------------------------------
   // internal conversion time
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ  = 100;
   localparam int CONV_TIME_NS = 7500;
   localparam int CONV_CYCLES  = (CONV_TIME_NS * SYS_CLK_MHZ) / 1000;
   // ----------------------------------------------------------------
   // link state machine
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ACSC_IDLE  = 2'b00,
      ACSC_CTRL  = 2'b01,
      ACSC_EXT   = 2'b11,
      ACSC_INT   = 2'b10
   } acsc_state_t;
endpackage
